/* File: design/msr_regs_top.sv */
// Top: miscellaneous system registers with ready flag, straps and timer
`timescale 1ns/100ps

// Overview of operation
// [RULE_01] Byte-order register always returns fixed pattern
// [RULE_02] Reads during reset return non-pattern data
// [RULE_03] Either 16-bit half readable on its own
// [RULE_04] Ready flag sets after device has settled
// [RULE_05] Ready rising raises event when enabled
// [RULE_06] Host avoids most registers while not ready
// [RULE_07] Strap bits latched at reset, loader rewritable
// [RULE_08] PHY override settings replace latched strap
// [RULE_09] Enable bit runs or halts timer, resets low
// [RULE_10] Enable falling edge forces preload to ones
// [RULE_11] Preload gives start value, resets ones
// [RULE_12] Count field shows present value, resets ones
// [RULE_13] Timer raises periodic event at preload interval
// [RULE_14] Zero crossing flags event, counting continues
// [RULE_15] Read-only and reserved writes ignored, reserved zero
module msr_regs_top #(
    parameter int SETTLE_CYCLES = msr_pkg::MSR_SETTLE_CYCLES,
    parameter int TICK_DIV = msr_pkg::MSR_TICK_DIV
) (
    input wire logic CLK_IN,                 // System clock, 250 MHz
    input wire logic RSTN_IN,                // Async reset, active low
    input wire logic [8:0] REG_ADDR_IN,      // Register byte address
    input wire logic REG_RD_IN,              // Read strobe, one cycle
    input wire logic REG_WR_IN,              // Write strobe, one cycle
    input wire logic [31:0] REG_WDATA_IN,    // Write data
    input wire logic REG_HALF_MODE_IN,       // 16-bit half access
    input wire logic REG_HALF_SEL_IN,        // Half select, 1 = upper
    output logic [31:0] REG_RDATA_OUT,       // Read data, registered
    output logic REG_RVALID_OUT,             // Read data valid pulse
    input wire logic [1:0] STRAP_IN,         // Crossover straps, PHY2..1
    input wire logic LOADER_BUSY_IN,         // Config loader running
    input wire logic LOADER_STRAP_WR_IN,     // Loader rewrites straps
    input wire logic [1:0] LOADER_STRAP_IN,  // Loader strap value
    input wire logic [1:0] OVR_CTRL_IN,      // PHY override control
    input wire logic [1:0] OVR_STATE_IN,     // PHY override state
    output logic [1:0] CROSSOVER_EN_OUT,     // Effective crossover enable
    input wire logic READY_EVT_EN_IN,        // Ready event enable
    output logic READY_EVT_OUT,              // Ready rising pulse
    output logic TIMER_EVT_OUT,              // Timer wrap pulse
    output logic READY_OUT                   // Device ready level
);
    import msr_pkg::*;

    localparam int SET_W = (SETTLE_CYCLES > 1) ? $clog2(SETTLE_CYCLES + 1) : 1;
    localparam logic [SET_W-1:0] SET_LAST = SET_W'(SETTLE_CYCLES);

    msr_timer_if tmr_if ();

    msr_ready_e state_r;
    msr_ready_e state_nxt;
    logic [SET_W-1:0] settle_r;
    logic ready_r;
    logic ready_evt_r;
    logic strap_taken_r;
    logic [1:0] strap_r;
    logic enable_r;
    logic [15:0] preload_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic [31:0] word;
    logic cfg_wr;

    // Register word as seen at a given address; unmapped reads zero
    function automatic logic [31:0] reg_word(input logic [8:0] addr,
                                             input logic rdy,
                                             input logic [1:0] strap,
                                             input logic en,
                                             input logic [15:0] pre,
                                             input logic [15:0] cnt);
        logic [31:0] w;
        w = 32'h00000000;
        case (addr)
            MSR_OFF_BYTE_ORDER: w = MSR_BYTE_ORDER_PATTERN;      // see [RULE_01]
            MSR_OFF_HW_CONFIG: begin
                w[MSR_HW_READY_BIT] = rdy;                       // see [RULE_04]
                w[MSR_HW_STRAP2_BIT] = strap[1];                 // see [RULE_07]
                w[MSR_HW_STRAP1_BIT] = strap[0];
            end
            MSR_OFF_CD_CONFIG: begin
                w[MSR_CD_ENABLE_BIT] = en;
                w[MSR_CD_PRELOAD_MSB:0] = pre;
            end
            MSR_OFF_CD_VALUE: w[15:0] = cnt;                     // see [RULE_12]
            default: w = 32'h00000000;                           // see [RULE_15]
        endcase
        return w;
    endfunction : reg_word

    ////////////////////////////////////////////////////////////////////////
    // Ready sequencer: settle after reset, then wait for the loader
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MSR_ST_SETTLE: begin
                if (settle_r == SET_LAST) begin
                    state_nxt = MSR_ST_LOADER;
                end
            end
            MSR_ST_LOADER: begin
                if (!LOADER_BUSY_IN) begin
                    state_nxt = MSR_ST_READY;
                end
            end
            MSR_ST_READY: begin
                // A reload drops ready until the loader finishes again
                if (LOADER_BUSY_IN) begin
                    state_nxt = MSR_ST_LOADER;
                end
            end
            default: state_nxt = MSR_ST_SETTLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_r <= MSR_ST_SETTLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Settle counter, stops at its last value
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            settle_r <= '0;
        end else if (settle_r != SET_LAST) begin
            settle_r <= settle_r + 1'b1;
        end
    end

    // Ready flag and its rising-edge event
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ready_r <= 1'b0;
            ready_evt_r <= 1'b0;
        end else begin
            ready_r <= (state_nxt == MSR_ST_READY);                  // see [RULE_04]
            ready_evt_r <= READY_EVT_EN_IN && !ready_r
                           && (state_nxt == MSR_ST_READY);           // see [RULE_05]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: sampled by a clocked process on the first edge after
    // release, since an async reset may only load constants
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            strap_taken_r <= 1'b0;
            strap_r <= MSR_STRAP_RESET;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            strap_r <= STRAP_IN;                                     // see [RULE_07]
        end else if (LOADER_STRAP_WR_IN) begin
            strap_r <= LOADER_STRAP_IN;                              // see [RULE_07]
        end
    end

    // Per-PHY override of the latched strap
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            CROSSOVER_EN_OUT[i] = OVR_CTRL_IN[i] ? OVR_STATE_IN[i] : strap_r[i]; // see [RULE_08]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Countdown configuration; only the enable and preload are writable
    assign cfg_wr = REG_WR_IN && (REG_ADDR_IN == MSR_OFF_CD_CONFIG);   // see [RULE_15]

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            enable_r <= MSR_ENABLE_RESET;                            // see [RULE_09]
        end else if (cfg_wr) begin
            enable_r <= REG_WDATA_IN[MSR_CD_ENABLE_BIT];             // see [RULE_09]
        end
    end

    // Preload: the enable falling edge wins over the written value
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            preload_r <= MSR_PRELOAD_RESET;                          // see [RULE_11]
        end else if (cfg_wr && enable_r && !REG_WDATA_IN[MSR_CD_ENABLE_BIT]) begin
            preload_r <= MSR_PRELOAD_RESET;                          // see [RULE_10]
        end else if (cfg_wr) begin
            preload_r <= REG_WDATA_IN[MSR_CD_PRELOAD_MSB:0];         // see [RULE_11]
        end
    end

    assign tmr_if.enable = enable_r;
    assign tmr_if.preload = preload_r;

    msr_countdown #(
        .TICK_DIV(TICK_DIV)
    ) u_countdown (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .tmr(tmr_if.engine)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path; a half read has no side effect, so halves stand alone
    assign word = reg_word(REG_ADDR_IN, ready_r, strap_r, enable_r, preload_r,
                           tmr_if.count);

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rdata_r <= 32'h00000000;                                 // see [RULE_02]
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= REG_RD_IN;
            if (REG_RD_IN) begin
                if (REG_HALF_MODE_IN) begin
                    rdata_r <= {16'h0000, REG_HALF_SEL_IN ? word[31:16]
                                                          : word[15:0]}; // see [RULE_03]
                end else begin
                    rdata_r <= word;
                end
            end
        end
    end

    assign REG_RDATA_OUT = rdata_r;
    assign REG_RVALID_OUT = rvalid_r;
    assign READY_OUT = ready_r;
    assign READY_EVT_OUT = ready_evt_r;
    assign TIMER_EVT_OUT = tmr_if.wrap_pulse;                        // see [RULE_13]

endmodule : msr_regs_top

/* File: design/msr_pkg.sv */
// Package: register map, field layout, reset values and timing counts
package msr_pkg;

    // Register byte offsets
    localparam logic [8:0] MSR_OFF_BYTE_ORDER = 9'h064;
    localparam logic [8:0] MSR_OFF_HW_CONFIG = 9'h074;
    localparam logic [8:0] MSR_OFF_CD_CONFIG = 9'h08c;
    localparam logic [8:0] MSR_OFF_CD_VALUE = 9'h090;

    // Fixed byte-order pattern
    localparam logic [31:0] MSR_BYTE_ORDER_PATTERN = 32'h87654321;

    // Hardware configuration field positions
    localparam int MSR_HW_READY_BIT = 27;
    localparam int MSR_HW_STRAP2_BIT = 26;
    localparam int MSR_HW_STRAP1_BIT = 25;

    // Countdown configuration field positions
    localparam int MSR_CD_ENABLE_BIT = 29;
    localparam int MSR_CD_PRELOAD_MSB = 15;

    // Reset values
    localparam logic [15:0] MSR_PRELOAD_RESET = 16'hffff;
    localparam logic [15:0] MSR_COUNT_RESET = 16'hffff;
    localparam logic MSR_ENABLE_RESET = 1'b0;
    localparam logic [1:0] MSR_STRAP_RESET = 2'h0;

    // Timing: settle time after reset release, and timer tick divide
    localparam int MSR_CLK_PERIOD_NS = 4;
    localparam int MSR_SETTLE_TIME_NS = 64;
    localparam int MSR_SETTLE_CYCLES = (MSR_SETTLE_TIME_NS + MSR_CLK_PERIOD_NS - 1)
                                       / MSR_CLK_PERIOD_NS;
    localparam int MSR_TICK_DIV = 1;

    // Ready sequencer states
    typedef enum logic [1:0] {
        MSR_ST_SETTLE = 2'b00,
        MSR_ST_LOADER = 2'b01,
        MSR_ST_READY = 2'b10
    } msr_ready_e;

endpackage : msr_pkg

/* File: design/msr_timer_if.sv */
// Interface: carrier between register bank and countdown engine
`timescale 1ns/100ps
interface msr_timer_if;
    logic enable;
    logic [15:0] preload;
    logic [15:0] count;
    logic wrap_pulse;

    modport regs (output enable, output preload, input count, input wrap_pulse);
    modport engine (input enable, input preload, output count, output wrap_pulse);
endinterface : msr_timer_if

/* File: design/msr_countdown.sv */
// Countdown engine: 16-bit general countdown with periodic reload
`timescale 1ns/100ps
module msr_countdown #(
    parameter int TICK_DIV = msr_pkg::MSR_TICK_DIV
) (
    input wire logic clk_in,        // System clock
    input wire logic rstn_in,       // Async reset, active low
    msr_timer_if.engine tmr         // Enable/preload in, count/event out
);
    import msr_pkg::*;

    localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    logic [DIV_W-1:0] div_r;
    logic tick;
    logic enable_d_r;
    logic [15:0] count_r;
    logic wrap_r;

    ////////////////////////////////////////////////////////////////////////
    // Tick divider; restarts with the enable so the first period is exact
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r <= '0;
        end else if (!tmr.enable || div_r == DIV_LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign tick = tmr.enable && enable_d_r && (div_r == DIV_LAST);

    // Enable history for the start edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable_d_r <= MSR_ENABLE_RESET;
        end else begin
            enable_d_r <= tmr.enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count: load on start, decrement while running, hold while halted
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r <= MSR_COUNT_RESET;                 // see [RULE_12]
        end else if (tmr.enable && !enable_d_r) begin
            count_r <= tmr.preload;                     // see [RULE_11]
        end else if (tick) begin
            if (count_r == 16'h0000) begin
                count_r <= tmr.preload;                 // see [RULE_14]
            end else begin
                count_r <= count_r - 16'h0001;          // see [RULE_09]
            end
        end
    end

    // Event pulse each time the count passes zero
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wrap_r <= 1'b0;
        end else begin
            wrap_r <= tick && (count_r == 16'h0000);    // see [RULE_13]
        end
    end

    assign tmr.count = count_r;
    assign tmr.wrap_pulse = wrap_r;

endmodule : msr_countdown

/* File: testbench/msr_regs_asserts.sv */
// Checker: port-level assertions for the system register bank
`timescale 1ns/100ps
module msr_regs_asserts
    import msr_pkg::*;
#(
    parameter int SETTLE_CYCLES = 2,
    parameter int TICK_DIV = 1
) (
    input wire logic CLK_IN,                 // Clock
    input wire logic RSTN_IN,                // Reset, active low
    input wire logic [8:0] REG_ADDR_IN,      // Address
    input wire logic REG_RD_IN,              // Read strobe
    input wire logic REG_HALF_MODE_IN,       // Half access
    input wire logic REG_HALF_SEL_IN,        // Upper half
    input wire logic [31:0] REG_RDATA_OUT,   // Read data
    input wire logic REG_RVALID_OUT,         // Read valid
    input wire logic LOADER_BUSY_IN,         // Loader busy
    input wire logic [1:0] OVR_CTRL_IN,      // Override enable
    input wire logic [1:0] OVR_STATE_IN,     // Override value
    input wire logic [1:0] CROSSOVER_EN_OUT, // Effective crossover
    input wire logic READY_EVT_EN_IN,        // Ready event enable
    input wire logic READY_EVT_OUT,          // Ready event
    input wire logic TIMER_EVT_OUT,          // Timer event
    input wire logic READY_OUT               // Ready level
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Full-width and upper-half read qualifiers
    wire rd_full = REG_RD_IN && !REG_HALF_MODE_IN;
    wire rd_up = REG_RD_IN && REG_HALF_MODE_IN && REG_HALF_SEL_IN;
    ////////////////////////////////////////////////////////////////
    a_pattern_read: assert property (
        rd_full && REG_ADDR_IN == MSR_OFF_BYTE_ORDER |=> REG_RDATA_OUT == MSR_BYTE_ORDER_PATTERN)
        else $error("byte order pattern wrong");
    a_upper_half: assert property (
        rd_up && REG_ADDR_IN == MSR_OFF_BYTE_ORDER
        |=> REG_RDATA_OUT == {16'h0000, MSR_BYTE_ORDER_PATTERN[31:16]})
        else $error("upper half read wrong");
    // No disable here: the point is the value while reset is held
    a_reset_blank: assert property (disable iff (1'b0)
        !RSTN_IN |-> REG_RDATA_OUT != MSR_BYTE_ORDER_PATTERN)
        else $error("pattern visible in reset");
    a_ready_bit: assert property (
        rd_full && REG_ADDR_IN == MSR_OFF_HW_CONFIG |=> REG_RDATA_OUT[27] == $past(READY_OUT))
        else $error("ready bit differs from level");
    a_strap_field: assert property (
        rd_full && REG_ADDR_IN == MSR_OFF_HW_CONFIG && OVR_CTRL_IN == 2'h0
        |=> REG_RDATA_OUT[26:25] == $past(CROSSOVER_EN_OUT)
        && REG_RDATA_OUT[31:28] == 4'h0 && REG_RDATA_OUT[24:0] == 25'h0)
        else $error("strap or reserved bits wrong");
    a_ready_event: assert property (
        READY_EVT_OUT == ($rose(READY_OUT) && $past(READY_EVT_EN_IN)))
        else $error("ready event mismatch");
    a_override_sel: assert property (
        (CROSSOVER_EN_OUT & OVR_CTRL_IN) == (OVR_STATE_IN & OVR_CTRL_IN))
        else $error("override not applied");
    a_loader_holds: assert property (
        LOADER_BUSY_IN |=> !READY_OUT)
        else $error("ready while loader busy");
    a_read_answer: assert property (
        1'b1 |=> REG_RVALID_OUT == $past(REG_RD_IN))
        else $error("read valid timing wrong");
    c_ready: cover property ($rose(READY_OUT));
    c_timer: cover property (TIMER_EVT_OUT);
    c_half: cover property (rd_up);
endmodule : msr_regs_asserts

/* File: testbench/msr_host_model.sv */
// Host model: register port master issuing single-cycle strobes
`timescale 1ns/100ps
module msr_host_model (
    input wire logic clk_in,           // Clock
    input wire logic rvalid_in,        // Read valid
    input wire logic [31:0] rdata_in,  // Read data
    output logic [8:0] addr_out,       // Address
    output logic rd_out,               // Read strobe
    output logic wr_out,               // Write strobe
    output logic [31:0] wdata_out,     // Write data
    output logic [1:0] half_out        // Half mode, upper select
);
    // Idle bus; released lines take inverted values, never the last one
    initial begin
        {addr_out, wdata_out} = {9'h1ff, 32'h0000_0000};
        {rd_out, wr_out, half_out} = 4'h0;
    end
    // Write: strobe taken at one edge, then released
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1;
        {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(posedge clk_in);
        #1;
        {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
    endtask : wr
    // Read: answer stands in the cycle after the taken edge
    task automatic rd(input logic [8:0] a, input logic [1:0] h, output logic [31:0] d);
        @(posedge clk_in);
        #1;
        {addr_out, half_out, rd_out} = {a, h, 1'b1};
        @(posedge clk_in);
        #1;
        {addr_out, half_out, rd_out} = {~a, ~h, 1'b0};
        d = (rvalid_in === 1'b1) ? rdata_in : 32'hxxxx_xxxx;
    endtask : rd
endmodule : msr_host_model

/* File: testbench/tb_top.sv */
// Testbench top: register bank scenarios with host model and checker
`timescale 1ns/100ps
`define CHK(g, e) check(g, e)
module tb_top;
    import msr_pkg::*;
    logic clk = 0, rstn = 0, rd, wr, rvalid, lbusy = 1, lswr = 0, ren = 1;
    logic revt, tevt, rdy;
    logic [8:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] half, strap, lstrap = 0, oc = 0, os = 0, xen, ls;
    int seed = 32'h1918d4fa, failures = 0, compares = 0, cyc = 0, revts = 0;
    msr_regs_top #(.SETTLE_CYCLES(2), .TICK_DIV(1)) i_dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr), .REG_RD_IN(rd),
        .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_HALF_MODE_IN(half[1]),
        .REG_HALF_SEL_IN(half[0]), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .STRAP_IN(strap), .LOADER_BUSY_IN(lbusy), .LOADER_STRAP_WR_IN(lswr),
        .LOADER_STRAP_IN(lstrap), .OVR_CTRL_IN(oc), .OVR_STATE_IN(os),
        .CROSSOVER_EN_OUT(xen), .READY_EVT_EN_IN(ren), .READY_EVT_OUT(revt),
        .TIMER_EVT_OUT(tevt), .READY_OUT(rdy));
    msr_host_model i_host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
        .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata), .half_out(half));
    ////////////////////////////////////////////////////////////////
    // 250 MHz clock; cycle count and ready event tally
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (revt === 1'b1) revts <= revts + 1;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    // Expected full read of a status register with ready set
    function automatic logic [31:0] exp_reg(input logic [8:0] a);
        if (a == MSR_OFF_BYTE_ORDER) return MSR_BYTE_ORDER_PATTERN;
        if (a == MSR_OFF_HW_CONFIG) return {4'h0, 1'b1, ls, 25'h0};
        return 32'h0;
    endfunction : exp_reg
    // Bounded wait for ready (w=0) or timer event (w=1); t is its cycle
    task automatic waitfor(input int w, output int t);
        int n;
        n = 0;
        while (((w != 0) ? tevt : rdy) !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 40) begin
            failures++;
            $display("Error %0t: wait limit reached", $time);
        end
        t = cyc;
        @(posedge clk);
        #1;
    endtask : waitfor
    task automatic regs_reset();
        logic [31:0] d;
        i_host.rd(MSR_OFF_CD_CONFIG, 2'h0, d);
        `CHK(d, 32'h0000ffff);
        i_host.rd(MSR_OFF_CD_VALUE, 2'h0, d);
        `CHK(d, 32'h0000ffff);
    endtask : regs_reset
    task automatic summarize();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [15:0] p;
        int t0, t1;
        logic [8:0] offs[4] = '{MSR_OFF_BYTE_ORDER, MSR_OFF_HW_CONFIG, 9'h100, 9'h0fc};
        strap = $random(seed);
        ls = strap;
        repeat (10) @(posedge clk);
        `CHK(rdata !== MSR_BYTE_ORDER_PATTERN, 1'b1);
        #1 rstn = 1;
        i_host.rd(MSR_OFF_HW_CONFIG, 2'h0, d);
        `CHK(d, {5'h0, strap, 25'h0});
        i_host.rd(MSR_OFF_BYTE_ORDER, 2'h0, d);
        `CHK(d, MSR_BYTE_ORDER_PATTERN);
        lbusy = 0;
        waitfor(0, t0);
        `CHK(revts, 1);
        regs_reset();
        $display("Test reset and ready done");
        // Full and half reads, mapped and unmapped
        foreach (offs[i]) for (int s = 0; s < 3; s++) begin
            i_host.rd(offs[i], (s == 0) ? 2'h0 : 2'(s + 1), d);
            t0 = exp_reg(offs[i]);
            `CHK(d, (s == 0) ? t0 : {16'h0, (s == 2) ? t0[31:16] : t0[15:0]});
        end
        // Loader rewrites, overrides, ignored writes to read-only places
        repeat (4) begin
            lstrap = $random(seed);
            {oc, os} = $random(seed);
            lswr = 1;
            @(posedge clk);
            #1 lswr = 0;
            ls = lstrap;
            `CHK(xen, (oc & os) | (~oc & ls));
            oc = 0;
            i_host.wr(MSR_OFF_HW_CONFIG, $random(seed));
            i_host.wr(MSR_OFF_BYTE_ORDER, $random(seed));
            i_host.rd(MSR_OFF_HW_CONFIG, 2'h0, d);
            `CHK(d, exp_reg(MSR_OFF_HW_CONFIG));
            i_host.rd(MSR_OFF_BYTE_ORDER, 2'h0, d);
            `CHK(d, MSR_BYTE_ORDER_PATTERN);
        end
        d = $random(seed);
        i_host.wr(MSR_OFF_CD_CONFIG, d & 32'hdfffffff);
        i_host.rd(MSR_OFF_CD_CONFIG, 2'h0, t0);
        `CHK(t0, {16'h0, d[15:0]});
        $display("Test reads and straps done");
        // Periodic timer, halt and preload force
        p = 16'(3 + ($random(seed) & 7));
        i_host.wr(MSR_OFF_CD_CONFIG, 32'h20000000 | p);
        i_host.rd(MSR_OFF_CD_CONFIG, 2'h0, d);
        `CHK(d, 32'h20000000 | p);
        waitfor(1, t0);
        waitfor(1, t1);
        `CHK(t1 - t0, p + 1);
        i_host.rd(MSR_OFF_CD_VALUE, 2'h0, d);
        `CHK({d[31:16], 15'h0, d[15:0] <= p}, 32'h1);
        i_host.wr(MSR_OFF_CD_CONFIG, 32'h00000005);
        i_host.rd(MSR_OFF_CD_CONFIG, 2'h0, d);
        `CHK(d, 32'h0000ffff);
        i_host.rd(MSR_OFF_CD_VALUE, 2'h0, d);
        i_host.rd(MSR_OFF_CD_VALUE, 2'h0, t0);
        `CHK(t0, d);
        $display("Test timer done");
        // Second reset mid-run, ready event masked this time
        #1 rstn = 0;
        ren = 0;
        repeat (3) @(posedge clk);
        `CHK(rdata !== MSR_BYTE_ORDER_PATTERN, 1'b1);
        #1 rstn = 1;
        ls = strap;
        waitfor(0, t0);
        `CHK(revts, 1);
        regs_reset();
        $display("Test second reset done");
        summarize();
    end
    // Watchdog against a hung wait
    initial begin
        #100000;
        failures++;
        $display("Error %0t: timeout", $time);
        summarize();
    end
endmodule : tb_top

bind msr_regs_top msr_regs_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .TICK_DIV(TICK_DIV)) i_chk (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_HALF_MODE_IN(REG_HALF_MODE_IN), .REG_HALF_SEL_IN(REG_HALF_SEL_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
    .LOADER_BUSY_IN(LOADER_BUSY_IN), .OVR_CTRL_IN(OVR_CTRL_IN), .OVR_STATE_IN(OVR_STATE_IN),
    .CROSSOVER_EN_OUT(CROSSOVER_EN_OUT), .READY_EVT_EN_IN(READY_EVT_EN_IN),
    .READY_EVT_OUT(READY_EVT_OUT), .TIMER_EVT_OUT(TIMER_EVT_OUT), .READY_OUT(READY_OUT));
